// ---- verilog/pab_arbiter.sv ----
// Bus arbiter and configuration address/data port of the system controller.
// Function
// - Agent needing the bus asserts its request.
// - Arbiter grants requester; it then starts transaction.
// - Current owner may restart without new request while locked.
// - Competing requesters ordered least recently used.
// - Idle bus parks on host bridge.
// - Revoke on release or 16 idle clocks.
// - Idle ISA bridge holds until ISA master leaves.
// - Retried master drops request three clocks.
// - Mask request of a just retried agent.
// - Locking master keeps top priority.
// - No ISA bridge grant while bus locked.
// - Masters keep lock periods short.
// - Address cycle then data cycles, one clock each.
// - Address cycle carries cycle type; agents decode.
// - Memory bursts advance address four bytes.
// - Two 32-bit registers: address and data.
// - Address register full width; data any width.
// - Address register holds enable, bus, device, function, index.
// - Low bits select type 0 or 1.
// - Type 0 device number 0 to 20 drives one select line.
// - Type 1 request forwarded to secondary bus.
`timescale 1ns/1ns
module pab_arbiter (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   ce_i,
  pab_if.arbiter                      bus,
  output logic [pab_pkg::AGW-1:0]     owner_o,
  output logic                        busy_o,
  output logic                        locked_o,
  output logic                        cfg_enable_o
);
  import pab_pkg::*;

  localparam logic [4:0] CNT_LAST = 5'(GRANT_IDLE_CLKS - 1);
  localparam logic [1:0] HOLD_CNT = 2'(RETRY_HOLD_CLKS);

  pab_arb_t     st_q;
  pab_cfg_t     cf_q;
  pab_order_t   order_q;
  pab_agent_t   win;
  logic         win_found;
  logic         rel;
  logic         timeout;
  logic         own_req;
  logic         lock_q;
  logic [4:0]   cnt_q;
  logic [NA-1:0] mask_q;
  logic [NA-1:0] elig;
  logic [31:0]  ca_q;
  logic [CS_LINES-1:0] cs_vec;
  logic [4:0]   dev;

  function automatic pab_order_t to_bottom(pab_order_t o, pab_agent_t a);
    pab_order_t r;
    int         k;
    r = o;
    k = 0;
    for (int p = 0; p < NA; p++) begin
      if (o[p] != a) begin
        r[k] = o[p];
        k = k + 1;
      end
    end
    r[NA-1] = a;
    return r;
  endfunction

  // Requests that may compete this cycle.
  always_comb begin
    elig = ~bus.agent_bus_request_n & ~mask_q;
    if (lock_q) begin
      elig[AG_ISA] = 1'b0;
    end
  end

  // First eligible agent in the priority list wins.
  always_comb begin
    win_found = 1'b0;
    win = '0;
    for (int p = 0; p < NA; p++) begin
      if (!win_found && elig[order_q[p]]) begin
        win_found = 1'b1;
        win = order_q[p];
      end
    end
  end

  // Decides when the current owner loses the bus.
  always_comb begin
    own_req = ~bus.agent_bus_request_n[owner_o];
    timeout = (cnt_q == CNT_LAST) && !lock_q;
    case (st_q)
      ARB_GRANT: begin
        rel = bus.frame_n && ((!own_req && !lock_q)
          || (timeout && !(owner_o == AG_ISA && bus.isa_master_busy)));
      end
      ARB_BUSY: begin
        rel = bus.retry || (bus.frame_n && bus.irdy_n && !lock_q);
      end
      ARB_ISA_HOLD: begin
        rel = !bus.isa_master_busy;
      end
      default: begin
        rel = 1'b0;
      end
    endcase
  end

  // Grant state machine.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_q                  <= ARB_PARK;
      bus.agent_bus_grant_n <= '1;
      bus.host_park         <= 1'b1;
      owner_o               <= '0;
      busy_o                <= 1'b0;
      cnt_q                 <= '0;
    end else if (ce_i) begin
      case (st_q)
        ARB_PARK: begin
          if (win_found) begin
            bus.agent_bus_grant_n <= ~(NA'(1) << win);
            bus.host_park         <= 1'b0;
            owner_o               <= win;
            cnt_q                 <= '0;
            st_q                  <= ARB_GRANT;
          end
        end
        ARB_GRANT: begin
          if (!bus.frame_n) begin
            busy_o <= 1'b1;
            st_q   <= ARB_BUSY;
          end else if (rel) begin
            bus.agent_bus_grant_n <= '1;
            bus.host_park         <= 1'b1;
            st_q                  <= ARB_PARK;
          end else if (timeout) begin
            st_q <= ARB_ISA_HOLD;
          end else if (!lock_q) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ARB_BUSY: begin
          if (rel) begin
            bus.agent_bus_grant_n <= '1;
            bus.host_park         <= 1'b1;
            busy_o                <= 1'b0;
            st_q                  <= ARB_PARK;
          end else if (bus.frame_n && bus.irdy_n) begin
            busy_o <= 1'b0;
            cnt_q  <= '0;
            st_q   <= ARB_GRANT;
          end
        end
        ARB_ISA_HOLD: begin
          if (rel) begin
            bus.agent_bus_grant_n <= '1;
            bus.host_park         <= 1'b1;
            st_q                  <= ARB_PARK;
          end
        end
        default: begin
          st_q <= ARB_PARK;
        end
      endcase
    end
  end

  // Least recently used order; a released owner drops to the bottom.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int p = 0; p < NA; p++) begin
        order_q[p] <= AGW'(p);
      end
    end else if (ce_i && rel) begin
      order_q <= to_bottom(order_q, owner_o);
    end
  end

  // Lock is sampled as a level.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      lock_q   <= 1'b0;
      locked_o <= 1'b0;
    end else if (ce_i) begin
      lock_q   <= !bus.lock_n && !bus.host_park;
      locked_o <= !bus.lock_n && !bus.host_park;
    end
  end

  // Per agent retry mask with idle counter.
  genvar gi;
  generate
    for (gi = 0; gi < NA; gi++) begin : g_mask
      logic [1:0] idle_q;
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          idle_q     <= '0;
          mask_q[gi] <= 1'b0;
        end else if (ce_i) begin
          if (!bus.agent_bus_request_n[gi]) begin
            idle_q <= '0;
          end else if (idle_q != HOLD_CNT) begin
            idle_q <= idle_q + 2'h1;
          end
          if (st_q == ARB_BUSY && bus.retry && owner_o == AGW'(gi)) begin
            mask_q[gi] <= 1'b1;
          end else if (idle_q == HOLD_CNT) begin
            mask_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Type 0 select line from the device number.
  always_comb begin
    dev = ca_q[CA_DEV_LSB +: 5];
    if (dev <= 5'(MAX_CS_DEV)) begin
      cs_vec = CS_ONE << dev;
    end else begin
      cs_vec = '0;
    end
  end

  // Configuration address and data ports.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cf_q                   <= CF_IDLE;
      ca_q                   <= CA_RESET;
      cfg_enable_o           <= 1'b0;
      bus.io_ack             <= 1'b0;
      bus.io_rdata           <= '0;
      bus.cfg_req            <= 1'b0;
      bus.cfg_type1          <= 1'b0;
      bus.cfg_write          <= 1'b0;
      bus.cfg_addr           <= '0;
      bus.config_chip_select <= '0;
      bus.cfg_be             <= '0;
      bus.cfg_wdata          <= '0;
    end else if (ce_i) begin
      bus.io_ack   <= 1'b0;
      cfg_enable_o <= ca_q[CA_EN_BIT];
      case (cf_q)
        CF_IDLE: begin
          if (bus.io_wr || bus.io_rd) begin
            if (bus.io_addr == CFG_ADDR_OFS) begin
              bus.io_ack   <= 1'b1;
              bus.io_rdata <= (bus.io_be == BE_FULL) ? ca_q : '0;
              if (bus.io_wr && bus.io_be == BE_FULL) begin
                ca_q <= bus.io_wdata & CA_WR_MASK;
              end
            end else if (bus.io_addr == CFG_DATA_OFS
                && ca_q[CA_EN_BIT]) begin
              bus.cfg_req   <= 1'b1;
              bus.cfg_write <= bus.io_wr;
              bus.cfg_be    <= bus.io_be;
              bus.cfg_wdata <= bus.io_wdata;
              if (ca_q[CA_TYPE_LSB +: 2] == CT_TYPE1) begin
                bus.cfg_type1 <= 1'b1;
                bus.config_chip_select <= '0;
                bus.cfg_addr  <= {8'h00, ca_q[23:2], CT_TYPE1};
              end else begin
                bus.cfg_type1 <= 1'b0;
                bus.config_chip_select <= cs_vec;
                bus.cfg_addr  <= {cs_vec, ca_q[10:2], CT_TYPE0};
              end
              cf_q <= CF_WAIT;
            end else begin
              bus.io_ack   <= 1'b1;
              bus.io_rdata <= (bus.io_addr == CFG_DATA_OFS) ? NO_CFG_DATA
                                                           : '0;
            end
          end
        end
        CF_WAIT: begin
          if (bus.cfg_ack) begin
            bus.cfg_req  <= 1'b0;
            bus.io_ack   <= 1'b1;
            bus.io_rdata <= bus.cfg_rdata;
            cf_q         <= CF_IDLE;
          end
        end
        default: begin
          cf_q <= CF_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- verilog/pab_pkg.sv ----
// Shared constants and types of the PCI arbiter and configuration port.
package pab_pkg;
  localparam int               NA              = 5;
  localparam int               AGW             = 3;
  localparam int               PCI_CLK_NS      = 10;
  localparam int               GRANT_IDLE_CLKS = 16;
  localparam int               RETRY_HOLD_CLKS = 2;
  localparam int               CS_LINES        = 21;
  localparam int               MAX_CS_DEV      = 20;
  typedef logic [AGW-1:0]      pab_agent_t;
  typedef pab_agent_t [NA-1:0] pab_order_t;
  localparam pab_agent_t       AG_ISA          = 3'h0;
  localparam pab_agent_t       AG_P2P          = 3'h1;
  localparam logic [15:0]      CFG_ADDR_OFS    = 16'h0CF8;
  localparam logic [15:0]      CFG_DATA_OFS    = 16'h0CFC;
  localparam int               CA_EN_BIT       = 31;
  localparam int               CA_BUS_LSB      = 16;
  localparam int               CA_DEV_LSB      = 11;
  localparam int               CA_FN_LSB       = 8;
  localparam int               CA_REG_LSB      = 2;
  localparam int               CA_TYPE_LSB     = 0;
  localparam logic [31:0]      CA_WR_MASK      = 32'h80FF_FFFF;
  localparam logic [31:0]      CA_RESET        = 32'h0000_0000;
  localparam logic [1:0]       CT_TYPE0        = 2'h0;
  localparam logic [1:0]       CT_TYPE1        = 2'h1;
  localparam logic [3:0]       BE_FULL         = 4'hF;
  localparam logic [31:0]      NO_CFG_DATA     = 32'hFFFF_FFFF;
  localparam logic [31:0]      DWORD_STEP      = 32'h0000_0004;
  localparam logic [CS_LINES-1:0] CS_ONE       = 21'h000001;
  typedef enum logic [3:0] {
    ARB_PARK     = 4'h1,
    ARB_GRANT    = 4'h2,
    ARB_BUSY     = 4'h4,
    ARB_ISA_HOLD = 4'h8
  } pab_arb_t;
  typedef enum logic [1:0] {
    CF_IDLE = 2'h1,
    CF_WAIT = 2'h2
  } pab_cfg_t;
  typedef enum logic [2:0] {
    MS_IDLE = 3'h1,
    MS_ADDR = 3'h2,
    MS_DATA = 3'h4
  } pab_mst_t;
endpackage

// ---- verilog/pab_if.sv ----
// Connection between the arbiter end and the bus agent end.
`timescale 1ns/1ns
interface pab_if;
  logic [pab_pkg::NA-1:0] agent_bus_request_n;
  logic [pab_pkg::NA-1:0] agent_bus_grant_n;
  logic                   host_park;
  logic                   frame_n;
  logic                   irdy_n;
  logic                   lock_n;
  logic                   retry;
  logic                   isa_master_busy;
  logic                   io_wr;
  logic                   io_rd;
  logic [15:0]            io_addr;
  logic [3:0]             io_be;
  logic [31:0]            io_wdata;
  logic                   io_ack;
  logic [31:0]            io_rdata;
  logic                   cfg_req;
  logic                   cfg_type1;
  logic                   cfg_write;
  logic [31:0]            cfg_addr;
  logic [pab_pkg::CS_LINES-1:0] config_chip_select;
  logic [3:0]             cfg_be;
  logic [31:0]            cfg_wdata;
  logic                   cfg_ack;
  logic [31:0]            cfg_rdata;
  modport arbiter (
    input  agent_bus_request_n, frame_n, irdy_n, lock_n, retry,
    input  isa_master_busy, io_wr, io_rd, io_addr, io_be, io_wdata,
    input  cfg_ack, cfg_rdata,
    output agent_bus_grant_n, host_park, io_ack, io_rdata, cfg_req,
    output cfg_type1, cfg_write, cfg_addr, config_chip_select, cfg_be,
    output cfg_wdata
  );
  modport agents (
    output agent_bus_request_n, frame_n, irdy_n, lock_n, retry,
    output isa_master_busy, io_wr, io_rd, io_addr, io_be, io_wdata,
    output cfg_ack, cfg_rdata,
    input  agent_bus_grant_n, host_park, io_ack, io_rdata, cfg_req,
    input  cfg_type1, cfg_write, cfg_addr, config_chip_select, cfg_be,
    input  cfg_wdata
  );
endinterface

// ---- verilog/pab_agents.sv ----
// Bus masters, host I/O port and configuration target facing the arbiter.
`timescale 1ns/1ns
module pab_agents (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   ce_i,
  pab_if.agents                       bus,
  input  wire logic [pab_pkg::NA-1:0] want_i,
  input  wire logic [31:0]            start_addr_i,
  input  wire logic [3:0]             beats_i,
  input  wire logic                   lock_i,
  input  wire logic                   retry_i,
  input  wire logic                   isa_busy_i,
  input  wire logic                   host_wr_i,
  input  wire logic                   host_rd_i,
  input  wire logic [15:0]            host_addr_i,
  input  wire logic [3:0]             host_be_i,
  input  wire logic [31:0]            host_wdata_i,
  input  wire logic [31:0]            cfg_rdata_i,
  output logic [31:0]                 ad_o,
  output logic                        xfer_done_o,
  output logic                        host_done_o,
  output logic [31:0]                 host_rdata_o
);
  import pab_pkg::*;

  localparam logic [1:0] HOLD_CNT = 2'(RETRY_HOLD_CLKS);

  pab_mst_t     ms_q;
  pab_agent_t   cur_q;
  pab_agent_t   gsel;
  logic         gany;
  logic [3:0]   left_q;

  // Which agent, if any, holds the grant.
  always_comb begin
    gany = 1'b0;
    gsel = '0;
    for (int i = 0; i < NA; i++) begin
      if (!bus.agent_bus_grant_n[i]) begin
        gany = 1'b1;
        gsel = AGW'(i);
      end
    end
  end

  // Request lines with retry backoff.
  genvar gi;
  generate
    for (gi = 0; gi < NA; gi++) begin : g_req
      logic [1:0] back_q;
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          back_q                     <= '0;
          bus.agent_bus_request_n[gi] <= 1'b1;
        end else if (ce_i) begin
          if (retry_i && ms_q == MS_DATA && cur_q == AGW'(gi)) begin
            back_q                     <= HOLD_CNT;
            bus.agent_bus_request_n[gi] <= 1'b1;
          end else if (back_q != 2'h0) begin
            back_q                     <= back_q - 2'h1;
            bus.agent_bus_request_n[gi] <= 1'b1;
          end else begin
            bus.agent_bus_request_n[gi] <= ~want_i[gi];
          end
        end
      end
    end
  endgenerate

  // Master transaction: one address cycle, then data cycles.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ms_q        <= MS_IDLE;
      cur_q       <= '0;
      left_q      <= '0;
      ad_o        <= '0;
      bus.frame_n <= 1'b1;
      bus.irdy_n  <= 1'b1;
      bus.retry   <= 1'b0;
      xfer_done_o <= 1'b0;
    end else if (ce_i) begin
      bus.retry   <= 1'b0;
      xfer_done_o <= 1'b0;
      case (ms_q)
        MS_IDLE: begin
          bus.irdy_n <= 1'b1;
          if (gany && want_i[gsel]
              && !xfer_done_o && !bus.retry) begin
            cur_q       <= gsel;
            ad_o        <= start_addr_i;
            left_q      <= beats_i;
            bus.frame_n <= 1'b0;
            ms_q        <= MS_ADDR;
          end
        end
        MS_ADDR: begin
          bus.irdy_n <= 1'b0;
          if (left_q <= 4'h1) begin
            bus.frame_n <= 1'b1;
          end
          ms_q <= MS_DATA;
        end
        MS_DATA: begin
          ad_o <= ad_o + DWORD_STEP;
          if (retry_i || left_q <= 4'h1) begin
            bus.retry   <= retry_i;
            bus.frame_n <= 1'b1;
            bus.irdy_n  <= 1'b1;
            xfer_done_o <= !retry_i;
            ms_q        <= MS_IDLE;
          end else begin
            left_q <= left_q - 4'h1;
            if (left_q == 4'h2) begin
              bus.frame_n <= 1'b1;
            end
          end
        end
        default: begin
          ms_q <= MS_IDLE;
        end
      endcase
    end
  end

  // Lock, ISA activity and host I/O are registered toward the arbiter.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bus.lock_n          <= 1'b1;
      bus.isa_master_busy <= 1'b0;
      bus.io_wr           <= 1'b0;
      bus.io_rd           <= 1'b0;
      bus.io_addr         <= '0;
      bus.io_be           <= '0;
      bus.io_wdata        <= '0;
      host_done_o         <= 1'b0;
      host_rdata_o        <= '0;
    end else if (ce_i) begin
      bus.lock_n          <= ~lock_i;
      bus.isa_master_busy <= isa_busy_i;
      bus.io_wr           <= host_wr_i;
      bus.io_rd           <= host_rd_i;
      bus.io_addr         <= host_addr_i;
      bus.io_wdata        <= host_wdata_i;
      if (host_addr_i == CFG_ADDR_OFS) begin
        bus.io_be <= BE_FULL;
      end else begin
        bus.io_be <= host_be_i;
      end
      host_done_o  <= bus.io_ack;
      host_rdata_o <= bus.io_rdata;
    end
  end

  // Configuration target answers one cycle after each request.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bus.cfg_ack   <= 1'b0;
      bus.cfg_rdata <= '0;
    end else if (ce_i) begin
      bus.cfg_ack   <= bus.cfg_req && !bus.cfg_ack;
      bus.cfg_rdata <= cfg_rdata_i;
    end
  end
endmodule

// ---- testbench/pab_properties.sv ----
// Concurrent checks on the link between the arbiter end and the agent end.
`timescale 1ns/1ns
module pab_properties (
  input wire logic                         clk_sys_i,
  input wire logic                         reset_i,
  input wire logic [pab_pkg::NA-1:0]       agent_bus_request_n,
  input wire logic [pab_pkg::NA-1:0]       agent_bus_grant_n,
  input wire logic                         host_park,
  input wire logic                         frame_n,
  input wire logic                         lock_n,
  input wire logic                         retry,
  input wire logic                         io_wr,
  input wire logic                         io_rd,
  input wire logic [15:0]                  io_addr,
  input wire logic                         io_ack,
  input wire logic                         cfg_req,
  input wire logic                         cfg_ack,
  input wire logic                         cfg_type1,
  input wire logic [31:0]                  cfg_addr,
  input wire logic [pab_pkg::CS_LINES-1:0] config_chip_select
);
  import pab_pkg::*;
  logic [4:0] idle_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Counts granted cycles of a slot or P2P bridge owner without a frame or lock.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !frame_n || !lock_n || !agent_bus_grant_n[0] || host_park)
      idle_q <= 5'h00;
    else if (idle_q != 5'h1F)
      idle_q <= idle_q + 5'h01;
  end
  one_grant_a: assert property ($countones(~agent_bus_grant_n) <= 1)
    else $error("more than one grant active");
  park_flag_a: assert property (host_park == &agent_bus_grant_n)
    else $error("park flag disagrees with grants");
  grant_cause_a: assert property (!(|($past(agent_bus_grant_n) &
    ~agent_bus_grant_n & $past(agent_bus_request_n))))
    else $error("grant given without request");
  idle_limit_a: assert property (idle_q <= 5'h11)
    else $error("idle owner kept grant too long");
  isa_lock_a: assert property ($fell(agent_bus_grant_n[0]) |-> $past(lock_n))
    else $error("isa bridge granted while locked");
  addr_ack_a: assert property ((io_wr || io_rd) && io_addr == CFG_ADDR_OFS
    && !cfg_req |=> io_ack)
    else $error("address port not answered next cycle");
  cfg_seq_a: assert property ($rose(cfg_req) |=> cfg_ack ##1 (io_ack && !cfg_req))
    else $error("config cycle handshake out of order");
  type1_sel_a: assert property (cfg_req && cfg_type1 |->
    config_chip_select == '0 && cfg_addr[1:0] == CT_TYPE1)
    else $error("type 1 cycle malformed");
  type0_sel_a: assert property (cfg_req && !cfg_type1 |->
    $onehot0(config_chip_select) && cfg_addr[1:0] == CT_TYPE0 &&
    cfg_addr[31:11] == config_chip_select)
    else $error("type 0 chip select malformed");
  retry_free_a: assert property (retry && lock_n |-> ##[1:3] host_park)
    else $error("retried owner kept the bus");
  cfg_t1_c: cover property (cfg_req && cfg_type1);
  retry_c: cover property (retry);
  lock_c: cover property ($fell(lock_n));
  isa_c: cover property ($fell(agent_bus_grant_n[0]));
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench joining the arbiter end to the agent end.
`timescale 1ns/1ns
module testbench;
  import pab_pkg::*;
  logic                clk_sys_i  = 1'b0;
  logic                reset_i    = 1'b1;
  logic [NA-1:0]       want       = '0;
  logic [31:0]         start_addr = 32'h1000_0040;
  logic [3:0]          beats      = 4'h1;
  logic                lock       = 1'b0;
  logic                retry_in   = 1'b0;
  logic                host_wr    = 1'b0;
  logic                host_rd    = 1'b0;
  logic [15:0]         host_addr  = 16'h0000;
  logic [31:0]         host_wdata = 32'h0;
  logic [3:0]          host_be    = 4'hF;
  logic [31:0]         cfg_rdata  = 32'h0;
  logic [2:0]          owner;
  logic                locked, cfg_en, xfer_done, host_done, cap_t1;
  logic [31:0]         ad, host_rdata, cap_addr, rd;
  logic [CS_LINES-1:0] cap_cs;
  logic [3:0]          cap_be;
  int                  fails      = 0;
  int                  n_compared = 0;
  pab_if bus ();
  pab_arbiter pab_arbiter_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .ce_i(1'b1), .bus(bus), .owner_o(owner), .busy_o(),
    .locked_o(locked), .cfg_enable_o(cfg_en));
  pab_agents pab_agents_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .ce_i(1'b1), .bus(bus), .want_i(want), .start_addr_i(start_addr),
    .beats_i(beats), .lock_i(lock), .retry_i(retry_in), .isa_busy_i(1'b0),
    .host_wr_i(host_wr), .host_rd_i(host_rd), .host_addr_i(host_addr),
    .host_be_i(host_be), .host_wdata_i(host_wdata), .cfg_rdata_i(cfg_rdata),
    .ad_o(ad), .xfer_done_o(xfer_done), .host_done_o(host_done),
    .host_rdata_o(host_rdata));
  pab_properties pab_properties_inst (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .agent_bus_request_n(bus.agent_bus_request_n),
    .agent_bus_grant_n(bus.agent_bus_grant_n), .host_park(bus.host_park),
    .frame_n(bus.frame_n), .lock_n(bus.lock_n), .retry(bus.retry),
    .io_wr(bus.io_wr), .io_rd(bus.io_rd), .io_addr(bus.io_addr),
    .io_ack(bus.io_ack), .cfg_req(bus.cfg_req), .cfg_ack(bus.cfg_ack),
    .cfg_type1(bus.cfg_type1), .cfg_addr(bus.cfg_addr),
    .config_chip_select(bus.config_chip_select));
  always #(PCI_CLK_NS / 2) clk_sys_i = ~clk_sys_i;
  // Keeps the fields of the last configuration cycle seen on the link.
  always @(posedge clk_sys_i) begin
    if (bus.cfg_req === 1'b1) begin
      cap_addr = bus.cfg_addr;
      cap_cs = bus.config_chip_select;
      cap_t1 = bus.cfg_type1;
      cap_be = bus.cfg_be;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("TB: %0d compared, %0d mismatched", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic hang();
    chk(32'h0, 32'h1);
    tally_and_finish();
  endtask
  task automatic idle();
    int n;
    for (n = 0; n < 60 && bus.host_park !== 1'b1; n++) tick();
    if (bus.host_park !== 1'b1) hang();
    repeat (4) tick();
  endtask
  task automatic hio(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    host_wr = wr;
    host_rd = !wr;
    host_addr = a;
    host_wdata = d;
    tick();
    host_wr = 1'b0;
    host_rd = 1'b0;
    for (n = 0; n < 20 && host_done !== 1'b1; n++) tick();
    if (host_done !== 1'b1) hang();
    rd = host_rdata;
  endtask
  task automatic t_reset();
    tick();
    chk(bus.agent_bus_grant_n, 5'h1F);
    chk(bus.host_park, 1'b1);
    $display("TB: reset test done");
  endtask
  task automatic t_cfg();
    hio(1'b1, CFG_ADDR_OFS, 32'h0);
    hio(1'b0, CFG_DATA_OFS, 32'h0);
    chk(rd, NO_CFG_DATA);
    hio(1'b1, CFG_ADDR_OFS, 32'h8A12_5B04);
    hio(1'b0, CFG_ADDR_OFS, 32'h0);
    chk(rd, 32'h8012_5B04);
    chk(cfg_en, 1'b1);
    cfg_rdata = 32'h1234_5678;
    hio(1'b0, CFG_DATA_OFS, 32'h0);
    chk(rd, 32'h1234_5678);
    chk(cap_addr, 32'h0040_0304);
    chk(cap_cs, 21'h000800);
    hio(1'b1, CFG_ADDR_OFS, 32'h8012_5B05);
    hio(1'b1, CFG_DATA_OFS, 32'hCAFE_0001);
    chk(cap_addr, 32'h0012_5B05);
    chk(cap_t1, 1'b1);
    host_be = 4'h3;
    hio(1'b1, CFG_DATA_OFS, 32'h0000_BEEF);
    host_be = 4'hF;
    chk(cap_be, 4'h3);
    hio(1'b0, 16'h0080, 32'h0);
    chk(rd, 32'h0);
    $display("TB: config test done");
  endtask
  task automatic t_burst();
    int n;
    logic [31:0] prev;
    beats = 4'h4;
    want[2] = 1'b1;
    for (n = 0; n < 30 && bus.frame_n !== 1'b0; n++) tick();
    chk(ad, start_addr);
    chk(owner, 3'h2);
    want[2] = 1'b0;
    prev = ad;
    for (n = 0; n < 30 && xfer_done !== 1'b1; n++) begin
      tick();
      if (ad !== prev) chk(ad - prev, DWORD_STEP);
      prev = ad;
    end
    if (xfer_done !== 1'b1) hang();
    idle();
    $display("TB: burst test done");
  endtask
  task automatic t_lru();
    int n, k;
    logic [NA-1:0] g;
    logic [NA-1:0] seen [4];
    logic [NA-1:0] exp_g [4] = '{5'h17, 5'h0F, 5'h1B, 5'h17};
    beats = 4'h1;
    want = 5'h1C;
    k = 0;
    g = 5'h1F;
    for (n = 0; n < 300 && k < 4; n++) begin
      tick();
      if (g === 5'h1F && bus.agent_bus_grant_n !== 5'h1F) begin
        seen[k] = bus.agent_bus_grant_n;
        k++;
      end
      g = bus.agent_bus_grant_n;
    end
    want = '0;
    if (k < 4) hang();
    for (k = 0; k < 4; k++) chk(seen[k], exp_g[k]);
    idle();
    $display("TB: priority test done");
  endtask
  task automatic t_retry();
    int n, gap;
    beats = 4'h4;
    want[3] = 1'b1;
    for (n = 0; n < 30 && bus.irdy_n !== 1'b0; n++) tick();
    retry_in = 1'b1;
    tick();
    retry_in = 1'b0;
    for (n = 0; n < 10 && bus.agent_bus_grant_n[3] !== 1'b1; n++) tick();
    chk(bus.agent_bus_grant_n[3], 1'b1);
    gap = 0;
    for (n = 0; n < 30 && bus.agent_bus_grant_n[3] !== 1'b0; n++) begin
      tick();
      gap++;
    end
    want[3] = 1'b0;
    chk(32'(gap >= 3), 32'h1);
    chk(bus.agent_bus_grant_n[3], 1'b0);
    idle();
    $display("TB: retry test done");
  endtask
  task automatic t_lock();
    int n;
    beats = 4'h1;
    lock = 1'b1;
    want[4] = 1'b1;
    for (n = 0; n < 30 && bus.agent_bus_grant_n[4] !== 1'b0; n++) tick();
    want[0] = 1'b1;
    repeat (30) tick();
    chk(bus.agent_bus_grant_n, 5'h0F);
    chk(locked, 1'b1);
    lock = 1'b0;
    want[4] = 1'b0;
    for (n = 0; n < 60 && bus.agent_bus_grant_n[0] !== 1'b0; n++) tick();
    chk(bus.agent_bus_grant_n[0], 1'b0);
    want[0] = 1'b0;
    idle();
    $display("TB: lock test done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_cfg();
    t_burst();
    t_lru();
    t_retry();
    t_lock();
    tally_and_finish();
  end
endmodule
